// >>> swm_pkg.sv
/*
 * constants, types and register map of the word-wide serial management bus master.
 * assumes one attached slave at bus address 0x12 and open-drain lines with pull-ups.
 */
package swm_pkg;

    // slave address byte, direction bit included
    localparam logic [7:0] SWM_ADDR_WR = 8'h12;
    localparam logic [7:0] SWM_ADDR_RD = 8'h13;

    // identification commands of the attached device
    localparam logic [7:0] SWM_CMD_MAKER = 8'hFE;
    localparam logic [7:0] SWM_CMD_PART = 8'hFF;

    // register offsets on the software bus
    localparam logic [7:0] SWM_OFS_CTRL = 8'h00;
    localparam logic [7:0] SWM_OFS_WDATA = 8'h04;
    localparam logic [7:0] SWM_OFS_RDATA = 8'h08;
    localparam logic [7:0] SWM_OFS_STAT = 8'h0C;

    // control register fields
    localparam int SWM_CTRL_GO = 0;
    localparam int SWM_CTRL_RD = 1;
    localparam int SWM_CTRL_CMD_LSB = 8;

    // status register fields
    localparam int SWM_STAT_BUSY = 0;
    localparam int SWM_STAT_DONE = 1;
    localparam int SWM_STAT_NACK = 2;
    localparam int SWM_STAT_SUPPLY = 3;

    // reset values
    localparam logic [7:0] SWM_CMD_RST = 8'h00;
    localparam logic [15:0] SWM_DATA_RST = 16'h0000;

    // timing: bus clock period split in four quarters
    localparam int SWM_CLK_PERIOD_NS = 10;
    localparam int SWM_SCL_PERIOD_NS = 4000;
    localparam int SWM_CNT_W = 10;
    localparam logic [SWM_CNT_W-1:0] SWM_QTR_CYC = SWM_CNT_W'(SWM_SCL_PERIOD_NS / (4 * SWM_CLK_PERIOD_NS));

    // byte framing
    localparam logic [3:0] SWM_ACK_BIT = 4'h8;
    localparam logic [2:0] SWM_IDX_CMD = 3'h1;
    localparam logic [2:0] SWM_IDX_RD_LO = 3'h3;
    localparam logic [2:0] SWM_IDX_LAST_WR = 3'h3;
    localparam logic [2:0] SWM_IDX_LAST_RD = 3'h4;

    typedef enum logic [1:0] {
        SWM_IDLE,
        SWM_START,
        SWM_BIT,
        SWM_STOP
    } swm_state_t;

    typedef struct packed {
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } swm_req_t;

endpackage

// >>> swm_master.sv
/*
 * serial management bus master for read-word and write-word transfers, with an
 * ahb-lite register slave for software.
 * assumes open-drain bus lines resolved outside, pull-ups present, one slave,
 * and a supply-good level from the device side that is asynchronous to clk_sys.
 */
`timescale 1ns/1ps

module swm_master
    import swm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // bus clock line, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    // bus data line, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // device supply state
    input wire logic supply_good
);

    swm_state_t state;
    swm_req_t req;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] sup_sy;
    logic scl_s;
    logic sda_s;
    logic sup_s;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic take;
    logic wr_ctrl;
    logic wr_wdata;
    logic wr_stat;
    logic launch;
    logic [SWM_CNT_W-1:0] cnt;
    logic step;
    logic hold;
    logic [1:0] q;
    logic [3:0] bit_n;
    logic [2:0] bidx;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [15:0] rdata;
    logic nak;
    logic fin;
    logic err;
    logic done_f;
    logic nack_f;
    logic busy;

    // byte sent at a given position of the transfer
    function automatic logic [7:0] tx_byte(input logic [2:0] b);
        logic [7:0] v;
        case (b)
            3'h0: v = SWM_ADDR_WR;
            3'h1: v = req.cmd;
            3'h2: v = req.rd ? SWM_ADDR_RD : req.wdata[7:0];
            3'h3: v = req.rd ? 8'hFF : req.wdata[15:8];
            default: v = 8'hFF;
        endcase
        return v;
    endfunction

    // true when the byte at position b comes from the slave
    function automatic logic is_rx(input logic [2:0] b);
        return req.rd && (b >= SWM_IDX_RD_LO);
    endfunction

    // level the master puts on the data line for the current bit
    function automatic logic sda_level();
        logic v;
        v = 1'b1;
        if (bit_n != SWM_ACK_BIT) begin
            v = is_rx(bidx) ? 1'b1 : txb[7];
        end else if (is_rx(bidx)) begin
            v = (bidx == SWM_IDX_LAST_RD);
        end
        return v;
    endfunction

    // register read mux
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h00000000;
        if (a == SWM_OFS_CTRL) begin
            v[SWM_CTRL_CMD_LSB +: 8] = req.cmd;
            v[SWM_CTRL_RD] = req.rd;
        end else if (a == SWM_OFS_WDATA) begin
            v[15:0] = req.wdata;
        end else if (a == SWM_OFS_RDATA) begin
            v[15:0] = rdata;
        end else if (a == SWM_OFS_STAT) begin
            v[SWM_STAT_BUSY] = busy;
            v[SWM_STAT_DONE] = done_f;
            v[SWM_STAT_NACK] = nack_f;
            v[SWM_STAT_SUPPLY] = sup_s;
        end
        return v;
    endfunction

    // pin and supply synchronisers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            sup_sy <= 2'h0;
        end else begin
            scl_sy <= {scl_sy[0], scl_i};
            sda_sy <= {sda_sy[0], sda_i};
            sup_sy <= {sup_sy[0], supply_good};
        end
    end

    assign scl_s = scl_sy[1];
    assign sda_s = sda_sy[1];
    assign sup_s = sup_sy[1];
    // open-drain drivers only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // ahb-lite: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ap_wr <= 1'b0;
            ap_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            ap_wr <= take && hwrite;
            if (take) begin
                ap_addr <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux(haddr[7:0]);
            end
        end
    end

    assign wr_ctrl = ap_wr && (ap_addr == SWM_OFS_CTRL);
    assign wr_wdata = ap_wr && (ap_addr == SWM_OFS_WDATA);
    assign wr_stat = ap_wr && (ap_addr == SWM_OFS_STAT);
    assign busy = (state != SWM_IDLE);
    assign launch = wr_ctrl && hwdata[SWM_CTRL_GO] && !busy && sup_s;
    // request registers, frozen while a transfer runs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req.rd <= 1'b0;
            req.cmd <= SWM_CMD_RST;
            req.wdata <= SWM_DATA_RST;
        end else if (!busy) begin
            if (wr_ctrl) begin
                req.rd <= hwdata[SWM_CTRL_RD];
                req.cmd <= hwdata[SWM_CTRL_CMD_LSB +: 8];
            end
            if (wr_wdata) begin
                req.wdata <= hwdata[15:0];
            end
        end
    end
    // sticky status flags, a new event wins over a clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_f <= 1'b0;
            nack_f <= 1'b0;
        end else begin
            if (fin) begin
                done_f <= 1'b1;
            end else if (wr_stat && hwdata[SWM_STAT_DONE]) begin
                done_f <= 1'b0;
            end
            if (err) begin
                nack_f <= 1'b1;
            end else if (wr_stat && hwdata[SWM_STAT_NACK]) begin
                nack_f <= 1'b0;
            end
        end
    end
    // quarter-period timer; waits while a released clock is held low by the slave
    assign hold = scl_oe_n && !scl_s;
    assign step = (cnt == SWM_QTR_CYC - 1'b1) && !hold;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt <= '0;
        end else if (!busy || hold || step) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
    // bit and byte sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= SWM_IDLE;
            q <= 2'h0;
            bit_n <= 4'h0;
            bidx <= 3'h0;
            txb <= 8'hFF;
            rxb <= 8'h00;
            rdata <= SWM_DATA_RST;
            nak <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            fin <= 1'b0;
            err <= 1'b0;
        end else begin
            fin <= 1'b0;
            err <= 1'b0;
            case (state)
                SWM_IDLE: begin
                    scl_oe_n <= 1'b1;
                    sda_oe_n <= 1'b1;
                    q <= 2'h0;
                    if (launch) begin
                        state <= SWM_START;
                        bidx <= 3'h0;
                        nak <= 1'b0;
                    end
                end
                SWM_START: begin
                    if (step) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: sda_oe_n <= 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b0;
                            default: begin
                                scl_oe_n <= 1'b0;
                                state <= SWM_BIT;
                                bit_n <= 4'h0;
                                txb <= tx_byte(bidx);
                            end
                        endcase
                    end
                end
                SWM_BIT: begin
                    if (step) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: sda_oe_n <= sda_level();
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (bit_n != SWM_ACK_BIT) begin
                                    rxb <= {rxb[6:0], sda_s};
                                    txb <= {txb[6:0], 1'b1};
                                end else if (!is_rx(bidx) && sda_s) begin
                                    nak <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                if (bit_n != SWM_ACK_BIT) begin
                                    bit_n <= bit_n + 4'h1;
                                end else begin
                                    bit_n <= 4'h0;
                                    if (is_rx(bidx) && bidx == SWM_IDX_RD_LO) begin
                                        rdata[7:0] <= rxb;
                                    end
                                    if (nak) begin
                                        state <= SWM_STOP;
                                        err <= 1'b1;
                                    end else if (bidx == (req.rd ? SWM_IDX_LAST_RD : SWM_IDX_LAST_WR)) begin
                                        state <= SWM_STOP;
                                        if (req.rd) begin
                                            rdata[15:8] <= rxb;
                                        end
                                    end else if (req.rd && bidx == SWM_IDX_CMD) begin
                                        state <= SWM_START;
                                        bidx <= bidx + 3'h1;
                                    end else begin
                                        bidx <= bidx + 3'h1;
                                        txb <= tx_byte(bidx + 3'h1);
                                    end
                                end
                            end
                        endcase
                    end
                end
                SWM_STOP: begin
                    if (step) begin
                        q <= q + 2'h1;
                        case (q)
                            2'h0: sda_oe_n <= 1'b0;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b1;
                            default: begin
                                state <= SWM_IDLE;
                                fin <= 1'b1;
                            end
                        endcase
                    end
                end
                default: state <= SWM_IDLE;
            endcase
        end
    end

endmodule

// >>> swm_master_checker.sv
/*
 * concurrent checks on the ports of the serial management bus master.
 * assumes the open-drain enables are the master's only bus drive and one clk_sys domain.
 */
`timescale 1ns/1ps

module swm_master_checker
    import swm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // ahb-lite
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // open-drain enables
    input wire logic scl_oe_n,
    input wire logic sda_oe_n
);
    localparam int HALF_MIN = 2 * SWM_QTR_CYC - 2;
    localparam int HALF_MAX = 2 * SWM_QTR_CYC + 2;
    localparam int DATA_MIN = SWM_QTR_CYC - 4;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic [7:0] pulse_cnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // length of the current released and pulled spans of the clock line
    always_ff @(posedge clk_sys) begin
        if (rst || !scl_oe_n) begin
            hi_cnt <= 16'h0000;
        end else if (hi_cnt != 16'hFFFF) begin
            hi_cnt <= hi_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || scl_oe_n) begin
            lo_cnt <= 16'h0000;
        end else begin
            lo_cnt <= lo_cnt + 16'h0001;
        end
    end

    // clock pulses since the last start or repeated start
    always_ff @(posedge clk_sys) begin
        if (rst || ($fell(sda_oe_n) && scl_oe_n)) begin
            pulse_cnt <= 8'h00;
        end else if ($fell(scl_oe_n)) begin
            pulse_cnt <= pulse_cnt + 8'h01;
        end
    end

    sequence s_start;
        $fell(sda_oe_n) && scl_oe_n;
    endsequence

    sequence s_stop;
        $rose(sda_oe_n) && scl_oe_n;
    endsequence

    a_start_hold: assert property (s_start |-> scl_oe_n [*8] ##[1:600] !scl_oe_n)
        else $error("start not followed by clock low in time");
    a_stop_quiet: assert property (s_stop |=> (scl_oe_n && sda_oe_n) [*8])
        else $error("bus not left free after stop");
    a_data_scl_low: assert property ($changed(sda_oe_n) && scl_oe_n |-> hi_cnt >= DATA_MIN)
        else $error("data line moved early while clock released");
    a_high_phase: assert property ($fell(scl_oe_n) |-> hi_cnt >= HALF_MIN)
        else $error("clock high phase too short");
    a_low_phase: assert property ($rose(scl_oe_n) |-> lo_cnt >= HALF_MIN && lo_cnt <= HALF_MAX)
        else $error("clock low phase off its length");
    a_nine_clocks: assert property (s_stop |-> (pulse_cnt % 8'd9) == 8'd1)
        else $error("stop not on a nine clock byte boundary");
    a_bus_answer: assert property (hsel && htrans[1] && hready |=> hreadyout && !hresp)
        else $error("register bus answer not ready okay");
    a_reset_release: assert property ($fell(rst) |-> scl_oe_n && sda_oe_n && hreadyout && !hresp)
        else $error("lines not released after reset");
endmodule

bind swm_master swm_master_checker chk_u (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n)
);

// >>> swm_dev_model.sv
/*
 * behavioural word-register slave standing on the far side of the bus.
 * assumes open-drain lines with pull-ups resolved by the bench; pull high means drive data low.
 */
`timescale 1ns/1ps

module swm_dev_model
    import swm_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h00C7, // arbitrary value
    parameter logic [15:0] PART_ID = 16'h3C01 // arbitrary value
)
(
    // bus lines
    input wire logic scl,
    input wire logic sda,
    // control and status
    input wire logic awake,
    output logic pull,
    output logic [7:0] err_cnt
);
    logic [15:0] regs [0:255];
    logic restart;

    task automatic get_byte(output logic [7:0] v, output logic brk);
        brk = 1'b0;
        v = 8'h00;
        for (int k = 7; k >= 0; k--) begin
            @(posedge scl);
            v[k] = sda;
            @(negedge scl or sda);
            if (scl === 1'b1) begin
                brk = 1'b1;
                restart = (sda === 1'b0);
                return;
            end
        end
    endtask

    task automatic give_ack();
        pull = 1'b1;
        @(posedge scl);
        @(negedge scl);
        #300 pull = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] v, output logic m);
        for (int k = 7; k >= 0; k--) begin
            pull = ~v[k];
            @(posedge scl);
            @(negedge scl);
            #300;
        end
        pull = 1'b0;
        @(posedge scl);
        m = sda;
        @(negedge scl);
    endtask

    task automatic session();
        logic [7:0] a, c, lo, hi, x;
        logic [15:0] w;
        logic brk, m;
        restart = 1'b0;
        get_byte(a, brk);
        if (brk || !awake || a !== SWM_ADDR_WR) return;
        give_ack();
        get_byte(c, brk);
        if (brk) return;
        give_ack();
        get_byte(lo, brk);
        if (brk && restart) begin
            get_byte(x, brk);
            if (brk) return;
            if (x !== SWM_ADDR_RD) err_cnt++;
            give_ack();
            w = (c == SWM_CMD_MAKER) ? MAKER_ID : (c == SWM_CMD_PART) ? PART_ID : regs[c];
            put_byte(w[7:0], m);
            if (m !== 1'b0) err_cnt++;
            put_byte(w[15:8], m);
            if (m !== 1'b1) err_cnt++;
            return;
        end
        if (brk) return;
        give_ack();
        get_byte(hi, brk);
        if (brk) return;
        give_ack();
        get_byte(x, brk);
        if (brk && !restart && c < SWM_CMD_MAKER) regs[c] = {hi, lo};
    endtask

    initial begin
        pull = 1'b0;
        err_cnt = 8'h00;
        restart = 1'b0;
        for (int i = 0; i < 256; i++) regs[i] = 16'h0000;
        forever begin
            if (!restart) @(negedge sda iff (scl === 1'b1));
            session();
        end
    end
endmodule

// >>> swm_master_bench.sv
/*
 * self-checking bench: register bus master tasks driving word writes, word reads,
 * identity reads, supply gating and a missing-acknowledge transfer.
 * assumes the device model answers at bus address 0x12 and lines have pull-ups.
 */
`timescale 1ns/1ps

module swm_master_bench
    import swm_pkg::*;
;
    localparam logic [15:0] MAKER_EXP = 16'h00C7; // arbitrary value
    localparam logic [15:0] PART_EXP = 16'h3C01; // arbitrary value
    localparam logic [23:0] CMDS = {SWM_CMD_PART, SWM_CMD_MAKER, 8'h3B};
    localparam logic [47:0] EXPS = {PART_EXP, MAKER_EXP, 16'hC35A};
    logic clk_sys, rst, hsel, hwrite, supply_good, dev_awake;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n, dev_pull;
    logic [7:0] dev_err;
    wire logic scl_w = scl_oe_n ? 1'b1 : scl_o;
    wire logic sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~dev_pull;
    int bad_count = 0;
    int check_count = 0;

    swm_master dut_u (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .supply_good(supply_good)
    );

    swm_dev_model #(.MAKER_ID(MAKER_EXP), .PART_ID(PART_EXP)) dev_u (
        .scl(scl_w), .sda(sda_w), .awake(dev_awake), .pull(dev_pull), .err_cnt(dev_err)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb_go(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb_go(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb_go(1'b0, a, 32'h00000000, q);
        chk(q, exp);
    endtask

    task automatic run_done();
        logic [31:0] q;
        q = 32'h00000000;
        while (q[SWM_STAT_DONE] !== 1'b1) ahb_go(1'b0, SWM_OFS_STAT, 32'h00000000, q);
    endtask

    initial begin
        #950000;
        bad_count++;
        close_out();
    end

    initial begin
        rst <= 1'b1;
        hsel <= 1'b0;
        haddr <= 32'h00000000;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h00000000;
        supply_good <= 1'b0;
        dev_awake <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(SWM_OFS_CTRL, 32'h00000000);
        rd_chk(SWM_OFS_WDATA, 32'h00000000);
        rd_chk(SWM_OFS_RDATA, 32'h00000000);
        rd_chk(SWM_OFS_STAT, 32'h00000000);
        wr(8'h10, 32'hFFFFFFFF);
        rd_chk(8'h10, 32'h00000000);
        wr(SWM_OFS_CTRL, 32'h00003B01);
        repeat (8) @(posedge clk_sys);
        rd_chk(SWM_OFS_STAT, 32'h00000000);
        supply_good <= 1'b1;
        dev_awake <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(SWM_OFS_WDATA, 32'h0000C35A);
        wr(SWM_OFS_CTRL, 32'h00003B01);
        repeat (2) @(posedge clk_sys);
        rd_chk(SWM_OFS_STAT, 32'h00000009);
        wr(SWM_OFS_WDATA, 32'h00001111);
        rd_chk(SWM_OFS_WDATA, 32'h0000C35A);
        run_done();
        rd_chk(SWM_OFS_STAT, 32'h0000000A);
        chk({16'h0000, dev_u.regs[8'h3B]}, 32'h0000C35A);
        wr(SWM_OFS_STAT, 32'h00000006);
        for (int i = 0; i < 3; i++) begin
            wr(SWM_OFS_CTRL, {16'h0000, CMDS[8*i +: 8], 8'h03});
            run_done();
            rd_chk(SWM_OFS_RDATA, {16'h0000, EXPS[16*i +: 16]});
            rd_chk(SWM_OFS_STAT, 32'h0000000A);
            wr(SWM_OFS_STAT, 32'h00000006);
        end
        chk({24'h000000, dev_err}, 32'h00000000);
        dev_awake <= 1'b0;
        wr(SWM_OFS_CTRL, 32'h00003B01);
        run_done();
        rd_chk(SWM_OFS_STAT, 32'h0000000E);
        rd_chk(SWM_OFS_RDATA, {16'h0000, PART_EXP});
        wr(SWM_OFS_STAT, 32'h00000006);
        rd_chk(SWM_OFS_STAT, 32'h00000008);
        chk({16'h0000, dev_u.regs[8'h3B]}, 32'h0000C35A);
        close_out();
    end
endmodule
